// File: rtl/elcol_driver.sv
// elcol_driver: 32-channel column driver, shift register, hold latches, gates
// assumes controller pins are asynchronous to sys_clk and slower than it
// each input pin but sys_clk_in and reset_n_in passes a two-flop synchroniser before any logic reads it
// reset is synchronous and clears stages, latches and outputs to low
// a pin level must last two sys_clk periods or it may be missed
// the serial output is stage 32 itself, so a cascade adds no delay
// the electrode outputs trail the pins by three to five sys_clk edges
// limitation: the pin shift clock ceiling is set by sys_clk, not the pin
// REVERSE_ORDER only remaps the outputs; shifting is the same in both
// no registers are reachable by software
`timescale 1ns/100ps
`default_nettype none
module elcol_driver
#(
  parameter bit REVERSE_ORDER = 1'b0
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        shift_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        latch_transfer_strobe_in,
  input  wire logic        output_enable_in,
  output logic             serial_data_out,
  output logic [31:0]      electrode_outputs_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic        clk_s;
  logic        data_s;
  logic        strobe_s;
  logic        oe_s;
  logic        clk_d;
  logic        shift_edge;
  logic [31:0] shift_stages;
  logic [31:0] hold_latches;
  logic [31:0] next_outputs;
  logic [31:0] next_shift_stages;
  logic [31:0] next_hold_latches;

  ////////////////////////////////////////////////////////////////////////////
  // a rise is a high sample that follows a low one
  function automatic logic elcol_rise
  (
    input logic cur,
    input logic prev
  );
    return cur & ~prev;
  endfunction

  // stage 1 takes the new bit, every other stage its lower neighbour
  function automatic logic [31:0] elcol_shift_in
  (
    input logic [31:0] v,
    input logic        b
  );
    return {v[elcol_pkg::STAGE_COUNT-2:0], b};
  endfunction

  // disabled outputs are driven low, never left floating
  function automatic logic [31:0] elcol_gate
  (
    input logic [31:0] v,
    input logic        en
  );
    return en ? v : elcol_pkg::LATCH_RESET;
  endfunction

  // data is synchronised alongside the clock so they keep their relation;
  // limitation: pin clock must be well below sys_clk/2 (MAX_SHIFT_KHZ, 6250, lies above 5000)
  // shift clock pin
  elcol_sync u_sync_clk
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (shift_clk_in),
    .sync_out   (clk_s)
  );

  elcol_sync u_sync_data
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (serial_data_in),
    .sync_out   (data_s)
  );

  elcol_sync u_sync_strobe
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (latch_transfer_strobe_in),
    .sync_out   (strobe_s)
  );

  elcol_sync u_sync_oe
  (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (output_enable_in),
    .sync_out   (oe_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // previous shift clock level for the rise detector; it resets low, the
  // idle level of the pin, so no false rise follows reset
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      clk_d <= elcol_pkg::STAGE_RESET;
    end
    else
    begin
      clk_d <= clk_s;
    end
  end

  assign shift_edge = elcol_rise(clk_s, clk_d);

  ////////////////////////////////////////////////////////////////////////////
  // 32 shift stages
  always_comb
  begin
    next_shift_stages = shift_stages;
    if (shift_edge)
    begin
      next_shift_stages = elcol_shift_in(shift_stages, data_s);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      shift_stages <= elcol_pkg::LATCH_RESET;
    end
    else
    begin
      shift_stages <= next_shift_stages;
    end
  end

  assign serial_data_out = shift_stages[elcol_pkg::STAGE_COUNT-1];

  ////////////////////////////////////////////////////////////////////////////
  // transparent hold latches
  // modelled as a clocked follower; a true latch would dodge timing checks
  // trade-off: while open the latches trail the stages by one clock
  always_comb
  begin
    next_hold_latches = hold_latches;
    if (strobe_s)
    begin
      next_hold_latches = shift_stages;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      hold_latches <= elcol_pkg::LATCH_RESET;
    end
    else
    begin
      hold_latches <= next_hold_latches;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] elcol_reverse(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < elcol_pkg::STAGE_COUNT; i++)
    begin
      r[i] = v[elcol_pkg::STAGE_COUNT-1-i];
    end
    return r;
  endfunction

  always_comb
  begin
    next_outputs = elcol_gate(hold_latches, oe_s);
    if (REVERSE_ORDER)
    begin
      next_outputs = elcol_reverse(next_outputs);
    end
  end

  // data outputs registered to avoid glitches on the electrode pins
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      electrode_outputs_out <= elcol_pkg::LATCH_RESET;
    end
    else
    begin
      electrode_outputs_out <= next_outputs;
    end
  end
endmodule
`default_nettype wire

// File: rtl/elcol_pkg.sv
// elcol_pkg: shared constants for the electroluminescent column driver
// assumes a single 10 MHz system clock and synchronous active-low reset
package elcol_pkg;
  localparam int unsigned STAGE_COUNT   = 32;
  localparam int unsigned SYNC_DEPTH    = 2;
  localparam logic        STAGE_RESET   = 1'h0;
  localparam logic [31:0] LATCH_RESET   = 32'h0000_0000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // maximum shift clock rate, in kHz, and least latch strobe width, in ns
  localparam int unsigned MAX_SHIFT_KHZ = 6250;
  localparam int unsigned MIN_STROBE_NS = 80;
  // cycles of sys_clk a strobe must span: least time, rounded up, at least 1
  localparam int unsigned MIN_STROBE_CYC =
    ((MIN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((MIN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// File: rtl/elcol_sync.sv
// elcol_sync: two-flop synchroniser for one asynchronous pin
// assumes the pin is stable long compared to a sys_clk period
`timescale 1ns/100ps
`default_nettype none
module elcol_sync
(
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  // meta feeds sync_out only; nothing else reads it
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      meta     <= elcol_pkg::STAGE_RESET;
      sync_out <= elcol_pkg::STAGE_RESET;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// File: verif/elcol_driver_sva.sv
// elcol_driver_sva: port checks for the column driver
// assumes pins stay quiet during reset
`timescale 1ns/100ps
`default_nettype none
module elcol_driver_sva
(
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic        shift_clk_in,
  input wire logic        latch_transfer_strobe_in,
  input wire logic        output_enable_in,
  input wire logic        serial_data_out,
  input wire logic [31:0] electrode_outputs_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_serial_on_rise: assert property ($changed(serial_data_out) |->
    $past(shift_clk_in, 3) && !$past(shift_clk_in, 4))
    else $error("serial out moved without a clock rise");
  chk_oe_forces_low: assert property (!output_enable_in [*4] |->
    electrode_outputs_out == 32'h0) else $error("outputs not low");
  chk_out_gated: assert property (|electrode_outputs_out |->
    $past(output_enable_in, 3)) else $error("output high while disabled");
  chk_latch_holds: assert property
    ((!latch_transfer_strobe_in && output_enable_in) [*6] |->
    $stable(electrode_outputs_out)) else $error("closed latch changed");
  chk_serial_quiet: assert property (!shift_clk_in [*5] |->
    $stable(serial_data_out)) else $error("serial out moved, clock low");
  // either end holds stage 32, so both output orders are covered
  chk_strobe_loads: assert property
    ((latch_transfer_strobe_in && output_enable_in) [*4] |-> ##1
    (electrode_outputs_out[31] == serial_data_out ||
    electrode_outputs_out[0] == serial_data_out))
    else $error("strobe did not load the latches");
endmodule
bind elcol_driver elcol_driver_sva u_sva (.sys_clk_in, .reset_n_in,
  .shift_clk_in, .latch_transfer_strobe_in, .output_enable_in,
  .serial_data_out, .electrode_outputs_out);
`default_nettype wire

// File: verif/elcol_ctrl_model.sv
// elcol_ctrl_model: display controller feeding serial column data
// assumes a 100 ns clock; all pins move on its falling edge
`timescale 1ns/100ps
`default_nettype none
module elcol_ctrl_model
(
  input  wire logic sys_clk_in,
  output logic      shift_clk_out,
  output logic      data_out,
  output logic      strobe_out
);
  initial {shift_clk_out, data_out, strobe_out} = 3'h0;
  task automatic send(input logic [31:0] w, input logic le);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge sys_clk_in) data_out = w[i];
      repeat (2) @(negedge sys_clk_in);
      shift_clk_out = 1'h1;
      repeat (4) @(negedge sys_clk_in);
      shift_clk_out = 1'h0;
      // hold over: stale data would hide a late sample
      data_out = ~data_out;
    end
    if (le)
    begin
      repeat (4) @(negedge sys_clk_in) strobe_out = 1'h1;
      repeat (4) @(negedge sys_clk_in) strobe_out = 1'h0;
    end
    repeat (6) @(negedge sys_clk_in);
  endtask
endmodule
`default_nettype wire

// File: verif/elcol_driver_tb.sv
// elcol_driver_tb: random words through the column driver
// a reversed part is cascaded behind the first on its serial output
`timescale 1ns/100ps
`default_nettype none
module elcol_driver_tb;
  logic        clk = 1'h0, rst_n = 1'h0, oe = 1'h0;
  wire         sclk, sdat, stb, sout;
  wire  [31:0] q, qr;
  logic [31:0] w, held, held_r, pw;
  int          fails = 0, comparisons = 0;
  always #50 clk = ~clk;
  elcol_ctrl_model u_elcol_ctrl_model (.sys_clk_in(clk),
    .shift_clk_out(sclk), .data_out(sdat), .strobe_out(stb));
  elcol_driver u_elcol_driver (.sys_clk_in(clk), .reset_n_in(rst_n),
    .shift_clk_in(sclk), .serial_data_in(sdat),
    .latch_transfer_strobe_in(stb), .output_enable_in(oe),
    .serial_data_out(sout), .electrode_outputs_out(q));
  elcol_driver #(.REVERSE_ORDER(1'b1)) u_elcol_driver_rev
    (.sys_clk_in(clk), .reset_n_in(rst_n), .shift_clk_in(sclk),
    .serial_data_in(sout), .latch_transfer_strobe_in(stb),
    .output_enable_in(oe), .serial_data_out(),
    .electrode_outputs_out(qr));
  // first bit sent lands on bit 31; reversed parts mirror the word
  function automatic logic [31:0] exp_q(input logic [31:0] v,
    input logic en, input bit rev);
    logic [31:0] r;
    for (int i = 0; i < 32; i++)
      r[i] = en & (rev ? v[31-i] : v[i]);
    return r;
  endfunction
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2000000 fails++;
    results;
  end
  initial
  begin
    void'($urandom(97567));
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    pw = 32'h0;
    for (int k = 0; k < 10; k++)
    begin
      w = k == 0 ? 32'hffff_ffff : k == 1 ? 32'h8000_0001 : $urandom;
      oe = k < 2 ? 1'h1 : 1'($urandom);
      send_word: u_elcol_ctrl_model.send(w, 1'h1);
      chk(q, exp_q(w, oe, 1'b0));
      chk(qr, exp_q(pw, oe, 1'b1));
      chk_bit(sout, w[31]);
      held = exp_q(w, oe, 1'b0);
      held_r = exp_q(pw, oe, 1'b1);
      pw = w;
    end
    u_elcol_ctrl_model.send(~w, 1'h0);
    chk(q, held);
    chk(qr, held_r);
    chk_bit(sout, ~w[31]);
    @(negedge clk) oe = 1'h0;
    repeat (5) @(negedge clk);
    chk(q, 32'h0);
    chk(qr, 32'h0);
    results;
  end
endmodule
`default_nettype wire
